// >>> design/tcap_pkg.sv
package tcap_pkg;
	// word layout
	localparam int WORD_BITS = 8;
	localparam int CODE_BITS = 5;
	localparam int STANDBY_POS = 5;
	localparam int RSV_HI_POS = 7;
	localparam int RSV_LO_POS = 6;
	localparam logic [7:0] WORD_RESET = 8'h00;
	localparam logic [4:0] CODE_RESET = 5'h00;
	// clock and timing
	localparam int CLK_NS = 8;
	localparam real SCL_PERIOD_NS = 38.4;
	localparam real SCL_PHASE_NS = 13.2;
	localparam real EN_SETUP_NS = 19.2;
	localparam real EN_GAP_NS = 38.4;
	localparam real SETTLE_US = 12.0;
	localparam real WAKE_US = 70.0;
	// least times round up; settle and wake times round down
	localparam int SCL_PHASE_CYC = int'($ceil(SCL_PHASE_NS / CLK_NS));
	localparam int EN_SETUP_CYC = int'($ceil(EN_SETUP_NS / CLK_NS));
	localparam int EN_GAP_CYC = int'($ceil(EN_GAP_NS / CLK_NS));
	localparam int SETTLE_CYC = int'($floor(SETTLE_US * 1000.0 / CLK_NS));
	localparam int WAKE_CYC = int'($floor(WAKE_US * 1000.0 / CLK_NS));
	// apb map of the controller
	localparam logic [11:0] CMD_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;
	localparam int BUSY_POS = 0;
	localparam int DIV_RESET = 4;
endpackage

// >>> design/tcap_link_if.sv
interface tcap_link_if;
	logic sclk;
	logic sdata;
	logic latch_enable_in;
	modport master (output sclk, output sdata, output latch_enable_in);
	modport device (input sclk, input sdata, input latch_enable_in);
endinterface

// >>> design/tcap_device.sv
// Link rules for the device and the master
// R01: master raises enable before any clock
// R02: sample data on rising clock, MSB first
// R03: master changes data on falling clock
// R04: enable falling edge applies shifted word
// R05: no bit count, keep last eight
// R06: only enabled device takes the transfer
// R07: shared enable needs every device loaded
// R08: master sends zero in top two bits
// R09: bit five selects standby
// R10: low five bits are capacitance code
// R11: clock period and phases minimum times
// R12: enable low gap between transfers
// R13: enable to clock setup and hold
// R14: ignore link while enable low
// R15: settle twelve us, wake seventy us
module tcap_device
	import tcap_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC,
	parameter int WAKE_CYCLES = WAKE_CYC
) (
	input wire logic ref_clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	tcap_link_if.device link, // serial link pins
	output logic [4:0] cap_state_o, // active capacitance code
	output logic standby_select_o, // active standby flag
	output logic settled_o, // capacitance has settled
	output logic [7:0] tuning_control_word_o // last applied word
);
	import tcap_pkg::*;
	// a zero count would drop the settled flag for one cycle only, the same as a count of one
	if (SETTLE_CYCLES < 1 || WAKE_CYCLES < 1) begin : g_bad_counts
		$error("settle counts must be positive");
	end

	logic [2:0] clk_sync_reg, en_sync_reg;
	logic [1:0] dat_sync_reg;
	logic [7:0] shift_reg, word_reg;
	logic [31:0] settle_reg;
	logic settled_reg;
	wire clk_rise = clk_sync_reg[1] & ~clk_sync_reg[2];
	wire en_fall = ~en_sync_reg[1] & en_sync_reg[2];
	wire en_now = en_sync_reg[1];
	// standby exit takes the longer wake time
	wire waking = word_reg[STANDBY_POS] & ~shift_reg[STANDBY_POS];
	wire [31:0] settle_load = waking ? 32'(WAKE_CYCLES) : 32'(SETTLE_CYCLES);

	// pins pass two flops before any edge detect
	always_ff @(posedge ref_clk_i) begin
		clk_sync_reg <= {clk_sync_reg[1:0], link.sclk};
		dat_sync_reg <= {dat_sync_reg[0], link.sdata}; // no edge on data, two flops do
		en_sync_reg <= {en_sync_reg[1:0], link.latch_enable_in};
	end

	// shift only while enabled; no count kept
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			shift_reg <= WORD_RESET;
		end else if (en_now && clk_rise) begin // R02 R06 R14
			shift_reg <= {shift_reg[6:0], dat_sync_reg[1]}; // R05
		end
	end

	// apply on enable fall only
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			word_reg <= WORD_RESET;
		end else if (en_fall) begin
			word_reg <= shift_reg; // R04 R14
		end
	end

	// settle timer after each apply
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			settle_reg <= 32'h0;
			settled_reg <= 1'b1;
		end else if (en_fall) begin
			settle_reg <= settle_load; // R15
			settled_reg <= 1'b0;
		end else if (settle_reg > 32'h1) begin
			settle_reg <= settle_reg - 32'h1;
		end else begin
			settle_reg <= 32'h0;
			settled_reg <= 1'b1; // R15
		end
	end

	assign tuning_control_word_o = word_reg;
	assign cap_state_o = word_reg[CODE_BITS-1:0]; // R10
	assign standby_select_o = word_reg[STANDBY_POS]; // R09
	assign settled_o = settled_reg;
endmodule

// >>> design/tcap_master.sv
// Decided for this implementation: the register offsets and the APB slave port.
module tcap_master
	import tcap_pkg::*;
#(
	parameter int HALF_CYCLES = 3
) (
	input wire logic ref_clk_i, // system clock
	input wire logic rst_i, // sync reset, high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	tcap_link_if.master link // serial link pins
);
	import tcap_pkg::*;
	// the phase counter is eight bits wide, so too slow a link clock is refused as well
	localparam bit HALF_BAD = HALF_CYCLES < SCL_PHASE_CYC || HALF_CYCLES > 256
		|| 2 * HALF_CYCLES * CLK_NS < SCL_PERIOD_NS;
	if (HALF_BAD) begin : g_bad_half
		$error("HALF_CYCLES out of range for link clock timing");
	end

	typedef enum {IDLE, SETUP, LOW, HIGH, HOLD, GAP} state_t;
	state_t st_reg;
	logic [7:0] word_reg;
	logic [2:0] bit_reg;
	logic [7:0] cnt_reg;
	logic sclk_reg, sdat_reg, sen_reg;
	logic [31:0] prdata_reg;
	logic pready_reg, pslverr_reg;

	wire busy = (st_reg != IDLE);
	wire acc = psel & penable & ~pready_reg;
	wire hit_cmd = paddr == CMD_OFS;
	wire hit_stat = paddr == STAT_OFS;
	// a command lands on the edge that completes the transfer, and only if it was not refused
	wire fin = psel & penable & pready_reg;
	wire start = fin & pwrite & hit_cmd & ~pslverr_reg & ~busy;
	wire tdone = (cnt_reg == 8'h0);
	localparam logic [7:0] HALF = 8'(HALF_CYCLES - 1);
	localparam logic [7:0] SETUPC = 8'(EN_SETUP_CYC);
	localparam logic [7:0] GAPC = 8'(EN_GAP_CYC);

	// apb: one wait state; cmd write while busy is refused with error
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= acc;
			pslverr_reg <= acc & ~((hit_cmd & ~(pwrite & busy)) | (hit_stat & ~pwrite));
			prdata_reg <= (acc & hit_stat & ~pwrite) ? {31'h0, busy} : 32'h0;
		end
	end

	// serial sequencer; reserved bits forced zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_reg <= IDLE;
			word_reg <= WORD_RESET;
			bit_reg <= 3'h7;
			cnt_reg <= 8'h0;
			sclk_reg <= 1'b0;
			sdat_reg <= 1'b0;
			sen_reg <= 1'b0;
		end else begin
			unique case (st_reg)
				IDLE: if (start) begin
					word_reg <= {2'b00, pwdata[5:0]}; // R08
					sen_reg <= 1'b1; // R01
					cnt_reg <= SETUPC;
					bit_reg <= 3'h7; // R07
					sdat_reg <= 1'b0;
					st_reg <= SETUP;
				end
				SETUP: if (tdone) begin
					sdat_reg <= word_reg[7]; // R02 msb first
					cnt_reg <= HALF;
					st_reg <= LOW;
				end else cnt_reg <= cnt_reg - 8'h1; // R13
				LOW: if (tdone) begin
					sclk_reg <= 1'b1;
					cnt_reg <= HALF;
					st_reg <= HIGH;
				end else cnt_reg <= cnt_reg - 8'h1; // R11
				HIGH: if (tdone) begin
					sclk_reg <= 1'b0;
					cnt_reg <= HALF;
					if (bit_reg == 3'h0) begin
						st_reg <= HOLD;
					end else begin
						bit_reg <= bit_reg - 3'h1;
						sdat_reg <= word_reg[bit_reg - 3'h1]; // R03
						st_reg <= LOW;
					end
				end else cnt_reg <= cnt_reg - 8'h1; // R11
				HOLD: if (tdone) begin
					sen_reg <= 1'b0; // R13
					cnt_reg <= GAPC;
					st_reg <= GAP;
				end else cnt_reg <= cnt_reg - 8'h1;
				GAP: if (tdone) st_reg <= IDLE;
				else cnt_reg <= cnt_reg - 8'h1; // R12
			endcase
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign link.sclk = sclk_reg;
	assign link.sdata = sdat_reg;
	assign link.latch_enable_in = sen_reg;
endmodule

// >>> testbench/tcap_link_assertions.sv
module tcap_link_assertions (
	input wire logic ref_clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic sclk, // link clock
	input wire logic sdata, // link data
	input wire logic latch_enable_in // frame enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// clock rises in this frame; enable low clears it, so no stale count leaks over
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !latch_enable_in) cnt <= 4'h0;
		else if ($rose(sclk)) cnt <= cnt + 4'h1;
	end
	sequence en_kept;
		latch_enable_in [*3];
	endsequence
	idle_low_a: assert property (!latch_enable_in |-> !sclk)
		else $error("clock outside frame");
	data_steady_a: assert property ($changed(sdata) |-> !sclk)
		else $error("data moved with clock high");
	high_phase_a: assert property ($rose(sclk) |-> sclk [*2])
		else $error("clock high too short");
	low_phase_a: assert property ($fell(sclk) |-> !sclk [*2])
		else $error("clock low too short");
	en_setup_a: assert property ($rose(latch_enable_in) |-> !sclk [*3])
		else $error("enable setup short");
	en_hold_a: assert property ($rose(sclk) |-> en_kept)
		else $error("enable hold short");
	en_gap_a: assert property ($fell(latch_enable_in) |-> !latch_enable_in [*5])
		else $error("enable gap short");
	bit_count_a: assert property ($fell(latch_enable_in) |-> cnt == 4'h8)
		else $error("frame not eight bits");
	rsv_zero_a: assert property ($rose(sclk) && cnt < 4'h2 |-> !sdata)
		else $error("reserved bit set");
endmodule

// >>> testbench/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import tcap_pkg::*;
	// short settle and wake times keep the run small
	localparam logic [7:0] SETTLE_SIM = 8'h0A;
	localparam logic [7:0] WAKE_SIM = 8'h14;
	typedef struct {logic [31:0] d; logic [7:0] e; logic [7:0] s;} row_t;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pready, pslverr, er, sby, stl;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0] cap;
	logic [7:0] word, w2, prv = 8'h00, n_cyc;
	int n_errors = 0, checks = 0;
	// top bits of 0xFF must be dropped; FF then 00 leaves standby and takes the wake time
	row_t rows [5] = '{'{32'h1F, 8'h1F, SETTLE_SIM}, '{32'h20, 8'h20, SETTLE_SIM}, '{32'hFF, 8'h3F, SETTLE_SIM},
		'{32'h0, 8'h00, WAKE_SIM}, '{32'h15, 8'h15, SETTLE_SIM}};
	tcap_link_if l1();
	tcap_link_if l2();
	tcap_master i_tcap_master (.ref_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link(l1));
	tcap_device #(.SETTLE_CYCLES(SETTLE_SIM), .WAKE_CYCLES(WAKE_SIM)) i_tcap_device (.ref_clk_i, .rst_i, .link(l1),
		.cap_state_o(cap), .standby_select_o(sby), .settled_o(stl), .tuning_control_word_o(word));
	// second device fed by hand-made frames at a slow link clock
	tcap_device #(.SETTLE_CYCLES(10), .WAKE_CYCLES(20)) i_tcap_device_b (.ref_clk_i, .rst_i, .link(l2),
		.cap_state_o(), .standby_select_o(), .settled_o(), .tuning_control_word_o(w2));
	tcap_link_assertions i_tcap_link_assertions (.ref_clk_i, .rst_i, .sclk(l1.sclk), .sdata(l1.sdata),
		.latch_enable_in(l1.latch_enable_in));
	initial forever #4 ref_clk_i = ~ref_clk_i;
	task automatic end_of_test;
		if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one apb transfer; no wait count assumed, only the watchdog ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	// poll busy, then let the synchronised apply land
	task automatic idle;
		do apb(1'b0, STAT_OFS, 32'h0); while (rd[BUSY_POS] !== 1'b0);
		repeat (4) @(posedge ref_clk_i);
	endtask
	// 160 ns link clock; released data goes to its inverse
	task automatic frame(input logic [15:0] v, input int n, input logic en);
		l2.latch_enable_in <= en;
		for (int i = n - 1; i >= 0; i--) begin
			repeat (10) @(posedge ref_clk_i);
			{l2.sclk, l2.sdata} <= {1'b0, v[i]};
			repeat (10) @(posedge ref_clk_i);
			l2.sclk <= 1'b1;
		end
		repeat (10) @(posedge ref_clk_i);
		{l2.sclk, l2.sdata, l2.latch_enable_in} <= {1'b0, ~v[0], 1'b0};
		repeat (8) @(posedge ref_clk_i);
	endtask
	initial begin
		#200000;
		n_errors++;
		end_of_test;
	end
	initial begin
		{l2.sclk, l2.sdata, l2.latch_enable_in} = 3'b000;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			apb(1'b1, CMD_OFS, rows[i].d);
			wait (l1.latch_enable_in === 1'b1);
			chk(word, prv);
			// settle time counted from the first cycle the flag is seen low
			wait (l1.latch_enable_in === 1'b0);
			repeat (4) @(posedge ref_clk_i);
			n_cyc = 8'h00;
			while (stl !== 1'b1 && n_cyc < 8'h64) begin
				@(posedge ref_clk_i);
				n_cyc++;
			end
			chk(n_cyc, rows[i].s);
			idle;
			chk(word, rows[i].e);
			chk({2'b00, sby, cap}, rows[i].e);
			prv = rows[i].e;
		end
		// second write while busy is refused and leaves the first word
		apb(1'b1, CMD_OFS, 32'h0A);
		apb(1'b1, CMD_OFS, 32'h15);
		chk({7'h00, er}, 8'h01);
		idle;
		chk(word, 8'h0A);
		apb(1'b1, STAT_OFS, 32'h1);
		chk({7'h00, er}, 8'h01);
		apb(1'b0, 12'h008, 32'h0);
		chk({7'h00, er}, 8'h01);
		frame(16'h0B15, 12, 1'b1);
		chk(w2, 8'h15);
		frame(16'h001F, 8, 1'b0);
		chk(w2, 8'h15);
		// empty frame applies the shifter; bits clocked while disabled must not be in it
		frame(16'h0000, 0, 1'b1);
		chk(w2, 8'h15);
		// reset while a new word is still settling
		apb(1'b1, CMD_OFS, 32'h20);
		wait (l1.latch_enable_in === 1'b1);
		wait (l1.latch_enable_in === 1'b0);
		repeat (4) @(posedge ref_clk_i);
		chk({7'h00, stl}, 8'h00);
		rst_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk(word, 8'h00);
		chk({7'h00, stl}, 8'h01);
		end_of_test;
	end
endmodule
